// [design/duc_params.svh]
// Purpose: Constants for the DAC update and reset control block
// Assumes: 24-bit command words, 16 channels of 16 bits
// Notes: Commands sit in bits 23:20, channel select in bits 19:16
`ifndef DUC_PARAMS_SVH
`define DUC_PARAMS_SVH

// ==========================================================
// Command word layout
`define DUC_CMD_HI 23
`define DUC_CMD_LO 20
`define DUC_ADDR_HI 19
`define DUC_ADDR_LO 16
`define DUC_DATA_HI 15
`define DUC_DATA_LO 0

// ==========================================================
// Command codes
`define DUC_CMD_WR_INPUT 4'h1
`define DUC_CMD_UPD_DAC 4'h2
`define DUC_CMD_WR_UPD 4'h3
`define DUC_CMD_LOAD_MASK 4'h5
`define DUC_CMD_SOFT_RST 4'h6
`define DUC_CMD_REF_SETUP 4'h7

// ==========================================================
// Software reset key and reset values
`define DUC_SRST_ADDR 4'h0
`define DUC_SRST_KEY 16'h1234
`define DUC_MASK_RST 16'h0000
`define DUC_REF_RST 3'h0
`define DUC_REF_EN_BIT 0
`define DUC_CODE_ZERO 16'h0000
`define DUC_CODE_MID 16'h8000

// ==========================================================
// Power-on initialisation time
`define DUC_CLK_MHZ 125
`define DUC_POR_NS 1000
`define DUC_POR_CYC ((`DUC_POR_NS * `DUC_CLK_MHZ) / 1000)

`endif

// [design/duc_pkg.sv]
// Purpose: Types shared by the DAC update and reset control block
// Assumes: duc_params.svh supplies all numbers
// Notes: Types only
package duc_pkg;

    // ======================================================
    // Command word as received from the serial front end
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] chan;
        logic [15:0] data;
    } duc_word_t;

    // ======================================================
    // Pin synchroniser stages
    typedef struct packed {
        logic [2:0] load_sync;
        logic [2:0] hwrst_sync;
    } duc_sync_t;

    // ======================================================
    // Initialisation sequence
    typedef enum logic [1:0] {
        DUC_ST_WAIT_PIN,
        DUC_ST_POR,
        DUC_ST_RUN
    } duc_state_t;

endpackage

// [design/duc_pin_sync.sv]
// Purpose: Three-stage synchroniser for one asynchronous pin
// Assumes: Pin is asynchronous to clk
// Notes: Output changes only once stages two and three agree
`timescale 1ns/10ps
module duc_pin_sync
    import duc_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } duc_ps_t;

    duc_ps_t st_reg;
    duc_ps_t st_next;

    // ======================================================
    // Shift and agree; stage 0 feeds only stage 1
    always_comb begin
        st_next = st_reg;
        st_next.stage = {st_reg.stage[1:0], pin};
        if (st_reg.stage[1] == st_reg.stage[2]) begin
            st_next.level = st_reg.stage[2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= {{3{RST_VAL}}, RST_VAL};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;

endmodule

// [design/duc_ctrl.sv]
// Purpose: Load mask, write commands, resets and reference enable
// Assumes: Serial front end delivers whole 24-bit words as a pulse
// Notes: Pins are synchronised, so pin levels lag by four cycles
//
// Overview of operation
// - Command 0101 loads the mask from data bits; channel nibble ignored.
// - Mask clears to all zeros at reset; every channel follows strobe.
// - A channel with mask bit set ignores the falling strobe edge.
// - Command 0001 writes input; DAC also updates only if strobe low.
// - Command 0010 copies input to DAC register whatever the strobe.
// - Command 0011 writes both input and DAC registers whatever the strobe.
// - Falling strobe copies input to DAC on every unmasked channel.
// - Strobe held low ignores mask bits; writes update directly.
// - Low reset pin clears all outputs to the power-on code.
// - While reset pin is low, no output update is allowed.
// - After reset pin release, outputs hold cleared code until written or loaded from uncleared input registers.
// - Strobe and reset pin are ignored during power-on reset.
// - Reset pin low at power-up delays initialisation until released.
// - Power-up puts outputs at variant code until first valid write.
// - Soft reset needs command 0110, channel 0x0 and data 0x1234.
// - Valid soft reset restores power-on registers and restarts the power-on count, skipping the pin wait.
// - Internal reference enabled after power-up; setup bit cleared.
// - Command 0111 writes reference setup; bit 0 high disables it.
// - Reference setup ignores channel nibble; host writes reserved bits 0.
// - Command nibble in bits 23:20, channel nibble just below.
// - Words arrive as command byte, data MSB, data LSB.
// - Strobe high during writes then low updates unmasked outputs.
`timescale 1ns/10ps
`include "duc_params.svh"
module duc_ctrl
    import duc_pkg::*;
#(
    parameter logic MIDSCALE_VARIANT = 1'b0,
    parameter int POR_CYCLES = `DUC_POR_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic word_valid,
    input wire logic [23:0] word_data,
    input wire logic load_strobe_n,
    input wire logic hw_reset_n,
    output logic [255:0] dac_codes,
    output logic [15:0] load_strobe_mask,
    output logic [2:0] reference_setup,
    output logic ref_enable,
    output logic ready
);

    // ======================================================
    // State record
    typedef struct packed {
        duc_state_t state;
        logic [15:0] por_cnt;
        logic [15:0] mask;
        logic [2:0] ref_setup;
        logic load_prev;
        logic [15:0][15:0] in_regs;
        logic [15:0][15:0] dac_regs;
    } duc_ctrl_st_t;

    duc_ctrl_st_t st_reg;
    duc_ctrl_st_t st_next;
    logic load_lvl;
    logic hwrst_lvl;
    duc_word_t word;
    logic [15:0] por_code;
    logic load_fall;
    logic running;

    // ======================================================
    // Pin synchronisers
    duc_pin_sync #(
        .RST_VAL(1'b1)
    ) u_load_sync (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(load_strobe_n),
        .level(load_lvl)
    );

    // Reset pin starts out asserted; a pin held low at power-up
    // must never look released before it has passed all stages
    duc_pin_sync #(
        .RST_VAL(1'b0)
    ) u_hwrst_sync (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin(hw_reset_n),
        .level(hwrst_lvl)
    );

    // Word fields: command on top, channel below
    assign word = word_data;
    assign por_code = MIDSCALE_VARIANT ? `DUC_CODE_MID : `DUC_CODE_ZERO;
    assign running = (st_reg.state == DUC_ST_RUN);
    // Edge seen only once running; pins ignored during power-on
    assign load_fall = running && st_reg.load_prev && !load_lvl;

    // ======================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.load_prev = load_lvl;
        case (st_reg.state)
            DUC_ST_WAIT_PIN: begin
                // Initialisation waits for reset pin release
                if (hwrst_lvl) begin
                    st_next.state = DUC_ST_POR;
                    st_next.por_cnt = 16'h0000;
                end
            end
            DUC_ST_POR: begin
                // Pins ignored while counting out power-on
                if (st_reg.por_cnt >= 16'(POR_CYCLES - 1)) begin
                    st_next.state = DUC_ST_RUN;
                end else begin
                    st_next.por_cnt = st_reg.por_cnt + 16'h0001;
                end
            end
            DUC_ST_RUN: begin
                if (!hwrst_lvl) begin
                    // Clear outputs and block updates while held
                    for (int i = 0; i < 16; i++) begin
                        st_next.dac_regs[i] = por_code;
                    end
                end else begin
                    // Falling strobe loads unmasked channels
                    if (load_fall) begin
                        for (int i = 0; i < 16; i++) begin
                            if (!st_reg.mask[i]) begin
                                st_next.dac_regs[i] =
                                    st_reg.in_regs[i];
                            end
                        end
                    end
                    // Commands override strobe action on same cycle
                    if (word_valid) begin
                        case (word.cmd)
                            `DUC_CMD_WR_INPUT: begin
                                st_next.in_regs[word.chan] = word.data;
                                // Low strobe bypasses the mask
                                if (!load_lvl) begin
                                    st_next.dac_regs[word.chan] =
                                        word.data;
                                end
                            end
                            `DUC_CMD_UPD_DAC: begin
                                st_next.dac_regs[word.chan] =
                                    st_reg.in_regs[word.chan];
                            end
                            `DUC_CMD_WR_UPD: begin
                                st_next.in_regs[word.chan] = word.data;
                                st_next.dac_regs[word.chan] =
                                    word.data;
                            end
                            `DUC_CMD_LOAD_MASK: begin
                                st_next.mask = word.data;
                            end
                            `DUC_CMD_SOFT_RST: begin
                                if (word.chan == `DUC_SRST_ADDR &&
                                    word.data == `DUC_SRST_KEY) begin
                                    // Restart as after power-up
                                    st_next.state = DUC_ST_POR;
                                    st_next.por_cnt = 16'h0000;
                                    st_next.mask = `DUC_MASK_RST;
                                    st_next.ref_setup = `DUC_REF_RST;
                                    for (int i = 0; i < 16; i++) begin
                                        st_next.in_regs[i] = por_code;
                                        st_next.dac_regs[i] = por_code;
                                    end
                                end
                            end
                            `DUC_CMD_REF_SETUP: begin
                                // Channel nibble is don't-care
                                st_next.ref_setup =
                                    word.data[2:0];
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            default: begin
                st_next.state = DUC_ST_WAIT_PIN;
            end
        endcase
    end

    // ======================================================
    // Register; reset gives power-on code, empty mask, ref on
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg.state <= DUC_ST_WAIT_PIN;
            st_reg.por_cnt <= 16'h0000;
            st_reg.mask <= `DUC_MASK_RST;
            st_reg.ref_setup <= `DUC_REF_RST;
            st_reg.load_prev <= 1'b1;
            for (int i = 0; i < 16; i++) begin
                // Power-on code held until first write
                st_reg.in_regs[i] <= por_code;
                st_reg.dac_regs[i] <= por_code;
            end
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ======================================================
    // Outputs, all from flip-flops except ready and ref_enable
    assign dac_codes = st_reg.dac_regs;
    assign load_strobe_mask = st_reg.mask;
    assign reference_setup = st_reg.ref_setup;
    assign ref_enable = !st_reg.ref_setup[`DUC_REF_EN_BIT];
    // Words offered before ready are dropped, not queued
    assign ready = running;

endmodule

// [bench/duc_host_model.sv]
// Purpose: Host side model that hands whole command words to the block
// Assumes: Word assembly from the serial bytes is done before this point
// Notes: Bus shows junk once released, never the last word
`timescale 1ns/10ps
module duc_host_model (
    input wire logic clk,
    output logic word_valid,
    output logic [23:0] word_data
);
    // ==========================================================
    // Idle bus at time zero
    initial begin
        word_valid = 1'b0;
        word_data = 24'h000000;
    end
    // One word per pulse; command on top, channel just below
    task automatic send(input logic [3:0] c, input logic [3:0] a,
        input logic [15:0] d);
        @(posedge clk) #1;
        word_valid = 1'b1;
        word_data = {c, a, d};
        @(posedge clk) #1;
        word_valid = 1'b0;
        word_data = ~word_data; // Inverse so stale data is never reused
    endtask
endmodule

// [bench/duc_ctrl_checker.sv]
// Purpose: Port level checks of the update and reset control block
// Assumes: Pins pass a three stage synchroniser
// Notes: Bound into every duc_ctrl instance
`timescale 1ns/10ps
module duc_ctrl_checker #(
    parameter logic MIDSCALE_VARIANT = 1'b0,
    parameter int POR_CYCLES = 125
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic word_valid,
    input wire logic [23:0] word_data,
    input wire logic load_strobe_n,
    input wire logic hw_reset_n,
    input wire logic [255:0] dac_codes,
    input wire logic [15:0] load_strobe_mask,
    input wire logic [2:0] reference_setup,
    input wire logic ref_enable,
    input wire logic ready
);
    localparam logic [15:0] PC = MIDSCALE_VARIANT ? 16'h8000 : 16'h0000;
    logic [7:0] hr_cnt;
    logic tk;
    // ==========================================================
    // Cycles the reset pin has stayed high, saturating
    always_ff @(posedge clk) begin
        if (!rst_n || !hw_reset_n) begin
            hr_cnt <= 8'h00;
        end else if (hr_cnt != 8'hFF) begin
            hr_cnt <= hr_cnt + 8'h01;
        end
    end
    // Word surely taken: pin high long enough to pass the synchroniser
    assign tk = clk_en && word_valid && ready && hw_reset_n && hr_cnt > 5;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_hw_low;
        !hw_reset_n [*6];
    endsequence
    a_mask_load: assert property (tk && word_data[23:20] == 4'h5 |=> load_strobe_mask == $past(word_data[15:0])) else $error("mask not loaded");
    a_reset_vals: assert property ($rose(rst_n) |-> load_strobe_mask == 16'h0000 && reference_setup == 3'h0 && ref_enable && !ready && dac_codes == {16{PC}}) else $error("bad reset values");
    a_ref_write: assert property (tk && word_data[23:20] == 4'h7 |=> reference_setup == $past(word_data[2:0]) && ref_enable == !reference_setup[0]) else $error("bad reference setup");
    a_write_both: assert property (tk && word_data[23:20] == 4'h3 |=> dac_codes[$past(word_data[19:16]) * 16 +: 16] == $past(word_data[15:0])) else $error("write and update failed");
    a_hw_clear: assert property (s_hw_low |-> dac_codes == {16{PC}}) else $error("codes not cleared");
    a_masked_hold: assert property (ready && hw_reset_n && load_strobe_mask[3] && !word_valid |=> $stable(dac_codes[63:48])) else $error("masked channel moved");
    a_por_wait: assert property ($rose(ready) |-> hr_cnt > POR_CYCLES) else $error("ready too early");
    a_soft_key: assert property (tk && word_data == 24'h601234 |=> !ready && dac_codes == {16{PC}}) else $error("soft reset failed");
endmodule
bind duc_ctrl duc_ctrl_checker #(
    .MIDSCALE_VARIANT(MIDSCALE_VARIANT),
    .POR_CYCLES(POR_CYCLES)
) CHK (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .word_valid(word_valid), .word_data(word_data),
    .load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n),
    .dac_codes(dac_codes), .load_strobe_mask(load_strobe_mask),
    .reference_setup(reference_setup), .ref_enable(ref_enable),
    .ready(ready));

// [bench/duc_ctrl_bench.sv]
// Purpose: Self checking bench of the update and reset control block
// Assumes: Midscale variant, short power-on count of 4
// Notes: Pin changes are given six cycles to pass the synchroniser
`timescale 1ns/10ps
module duc_ctrl_bench;
    localparam logic [15:0] PC = 16'h8000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic load_strobe_n = 1'b1;
    logic hw_reset_n = 1'b0;
    logic word_valid;
    logic [23:0] word_data;
    logic [255:0] dac_codes;
    logic [15:0] load_strobe_mask;
    logic [2:0] reference_setup;
    logic ref_enable;
    logic ready;
    int err_total = 0;
    int checked = 0;
    // ==========================================================
    // Clock, design and host
    always #4 clk = ~clk;
    duc_ctrl #(.MIDSCALE_VARIANT(1'b1), .POR_CYCLES(4)) DUT (
        .clk(clk), .rst_n(rst_n), .clk_en(1'b1),
        .word_valid(word_valid), .word_data(word_data),
        .load_strobe_n(load_strobe_n), .hw_reset_n(hw_reset_n),
        .dac_codes(dac_codes), .load_strobe_mask(load_strobe_mask),
        .reference_setup(reference_setup), .ref_enable(ref_enable),
        .ready(ready));
    duc_host_model HST (.clk(clk), .word_valid(word_valid),
        .word_data(word_data));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [15:0] s,
        input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [15:0] cd(input int n);
        return dac_codes[16 * n +: 16];
    endfunction
    task automatic pins(input logic l, input logic h);
        @(posedge clk) #1;
        load_strobe_n = l;
        hw_reset_n = h;
        repeat (6) @(posedge clk);
        #1;
    endtask
    // Bounded wait for the power-on sequence to end
    task automatic wrdy();
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #100000;
        err_total++;
        test_done();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (20) @(posedge clk);
        #1 chk("ready", {15'h0, ready}, 16'h0);
        pins(1'b1, 1'b1);
        wrdy();
        chk("ready", {15'h0, ready}, 16'h1);
        chk("mask", load_strobe_mask, 16'h0);
        chk("refen", {15'h0, ref_enable}, 16'h1);
        chk("ch5", cd(5), PC);
        HST.send(4'h1, 4'h3, 16'h1111);
        chk("ch3", cd(3), PC);
        HST.send(4'h2, 4'h3, 16'h0000);
        chk("ch3", cd(3), 16'h1111);
        HST.send(4'h1, 4'h4, 16'hAAAA);
        HST.send(4'h1, 4'h3, 16'h2222);
        HST.send(4'h5, 4'hF, 16'h0008);
        chk("mask", load_strobe_mask, 16'h0008);
        pins(1'b0, 1'b1);
        chk("ch4", cd(4), 16'hAAAA);
        chk("ch3", cd(3), 16'h1111);
        HST.send(4'h1, 4'h3, 16'h3333);
        chk("ch3", cd(3), 16'h3333);
        pins(1'b1, 1'b1);
        HST.send(4'h3, 4'h7, 16'h1357);
        chk("ch7", cd(7), 16'h1357);
        HST.send(4'h7, 4'h9, 16'h0001);
        chk("refen", {15'h0, ref_enable}, 16'h0);
        HST.send(4'h7, 4'h0, 16'h0000);
        chk("refen", {15'h0, ref_enable}, 16'h1);
        pins(1'b1, 1'b0);
        chk("ch4", cd(4), PC);
        HST.send(4'h3, 4'h4, 16'h1234);
        chk("ch4", cd(4), PC);
        pins(1'b1, 1'b1);
        chk("ch4", cd(4), PC);
        HST.send(4'h3, 4'h2, 16'h4444);
        HST.send(4'h6, 4'h1, 16'h1234);
        HST.send(4'h6, 4'h0, 16'h1235);
        chk("ch2", cd(2), 16'h4444);
        HST.send(4'h6, 4'h0, 16'h1234);
        chk("ready", {15'h0, ready}, 16'h0);
        wrdy();
        chk("ch2", cd(2), PC);
        chk("mask", load_strobe_mask, 16'h0);
        test_done();
    end
endmodule
